// ==== logic/sgs_pkg.sv ====
`default_nettype none
package group_sel_pkg;
   localparam int NUM_GROUPS = 8;
   localparam int NUM_SIG = 30;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_USED = 8'h04;
   localparam logic [7:0] OFS_REMOTE = 8'h08;
   localparam logic [7:0] OFS_LOCAL = 8'h0C;
   localparam logic [7:0] OFS_FORCE = 8'h10;
   localparam logic [7:0] OFS_ACTIVE = 8'h14;
   localparam logic [7:0] OFS_ON_EN = 8'h18;
   localparam logic [7:0] OFS_OFF_EN = 8'h1C;
   localparam logic [7:0] OFS_EVT_INFO = 8'h20;
   localparam logic [7:0] OFS_EVT_TS = 8'h24;
   localparam logic [7:0] OFS_EVT_POP = 8'h28;
   localparam logic [7:0] OFS_INT_STATUS = 8'h2C;
   localparam logic [7:0] OFS_INT_MASK = 8'h30;
   // Field positions
   localparam int CTRL_FORCE_BIT = 0;
   localparam int ACT_FAIL_NOTCFG_BIT = 8;
   localparam int ACT_FAIL_FORCE_BIT = 9;
   localparam int ACT_FAIL_PRIO_BIT = 10;
   localparam int INFO_ON_BIT = 8;
   localparam int INFO_COUNT_LSB = 16;
   localparam int INFO_VALID_BIT = 31;
   localparam int INT_EVT_BIT = 0;
   localparam int INT_STALL_BIT = 1;
   localparam int INT_FAIL_BIT = 2;
   // Monitored signal indices
   localparam int SIG_REQ_LSB = 0;
   localparam int SIG_ACT_LSB = 8;
   localparam int SIG_USED_LSB = 16;
   localparam int SIG_REMOTE = 24;
   localparam int SIG_LOCAL = 25;
   localparam int SIG_FORCE = 26;
   localparam int SIG_FAIL_NOTCFG = 27;
   localparam int SIG_FAIL_FORCE = 28;
   localparam int SIG_FAIL_PRIO = 29;
   // Reset values
   localparam logic [7:0] USED_RST = 8'h01;
   localparam logic [2:0] ACTIVE_RST = 3'h0;
   localparam logic [29:0] EN_RST = 30'h3FFF_FFFF;
   localparam logic [29:0] SIG_RST = 30'h0001_0100;
   localparam logic [2:0] INT_MASK_RST = 3'h0;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_type;

   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } apb_rsp_type;

   typedef struct packed {
      logic [31:0] ts;
      logic [4:0] id;
      logic on;
   } evt_entry_type;
endpackage
`default_nettype wire

// ==== logic/group_selection_function.sv ====
// Notes on behaviour
// - Request one wins over all others
// - Request five blocks six, seven, eight
// - Request six ranks below one to five
// - Request six held blocks seven, eight
// - Request seven held blocks only eight
// - Request eight never blocks other groups
// - Pulse or level both count as request
// - Active group holds; no automatic return
// - ON and OFF event per signal change
// - Per-event ON/OFF storage enables
// - Every stored event carries time stamp
// - Unconfigured target raises failure status
// - Blocked lower request raises failure status
// - Failed forced change raises failure status
// - Remote, local, force change events
`default_nettype none
module group_selection_function
   import group_sel_pkg::*;
#(
   parameter int EVT_DEPTH = 8
) (
   input wire logic clk, // 100 MHz clock
   input wire logic sys_rst, // Synchronous reset
   input wire apb_req_type apb_in, // APB request
   output var apb_rsp_type apb_out, // APB response
   input wire logic [7:0] req_in, // Group request lines
   output logic [2:0] active_group, // Active group, 0 is group one
   output logic irq // Level interrupt
);
   localparam int AW = $clog2(EVT_DEPTH);
   localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(EVT_DEPTH);

   typedef struct packed {
      logic [2:0] active;
      logic [7:0] used;
      logic force_en;
      logic [7:0] rreq;
      logic [7:0] lreq;
      logic fvalid;
      logic [2:0] fgrp;
      logic fail_notcfg;
      logic fail_force;
      logic fail_prio;
      logic [29:0] prev;
      logic [29:0] on_en;
      logic [29:0] off_en;
      logic [29:0] pend_on;
      logic [29:0] pend_off;
      logic [31:0] tstamp;
      evt_entry_type [EVT_DEPTH-1:0] mem;
      logic [AW:0] count;
      logic [AW-1:0] rd_ptr;
      logic [AW-1:0] wr_ptr;
      logic [2:0] int_status;
      logic [2:0] int_mask;
      logic [31:0] prdata;
      logic pslverr;
   } state_type;

   state_type state_ff;
   state_type nxt_state;

   function automatic logic [4:0] first_set(input logic [31:0] v);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 31; i >= 0; i--) begin
         if (v[i]) begin
            r = 5'(i);
         end
      end
      return r;
   endfunction

   // Group code 1..8 to one-hot; zero or out of range gives none
   function automatic logic [7:0] decode_grp(input logic [3:0] code);
      logic [7:0] r;
      r = 8'h00;
      if (code != 4'h0 && code <= 4'h8) begin
         r = 8'h01 << (code - 4'h1);
      end
      return r;
   endfunction

   logic [7:0] comb_req;
   logic win_valid;
   logic [2:0] win;
   logic [4:0] win_idx;
   logic blocked;
   logic [29:0] sig;
   logic [29:0] new_on;
   logic [29:0] new_off;
   logic use_on;
   logic [4:0] pick_id;
   logic push;
   logic pop;
   logic wr_acc;
   logic rd_setup;
   evt_entry_type head;

   assign comb_req = req_in | state_ff.rreq | state_ff.lreq;
   assign win_valid = |comb_req;
   assign win_idx = first_set({24'h00_0000, comb_req});
   assign win = win_idx[2:0];
   assign blocked = win_valid && ((comb_req & ~(8'h01 << win)) != 8'h00);
   assign sig = {state_ff.fail_prio, state_ff.fail_force, state_ff.fail_notcfg, state_ff.force_en,
                 |state_ff.lreq, |state_ff.rreq, state_ff.used, 8'h01 << state_ff.active, req_in};
   assign new_on = sig & ~state_ff.prev & state_ff.on_en;
   assign new_off = ~sig & state_ff.prev & state_ff.off_en;
   assign use_on = |state_ff.pend_on;
   assign pick_id = first_set({2'b00, use_on ? state_ff.pend_on : state_ff.pend_off});
   assign push = (use_on || (|state_ff.pend_off)) && (state_ff.count != DEPTH_CNT);
   assign wr_acc = apb_in.psel && apb_in.penable && apb_in.pwrite;
   assign rd_setup = apb_in.psel && !apb_in.penable;
   assign pop = wr_acc && (apb_in.paddr == OFS_EVT_POP) && (state_ff.count != '0);
   assign head = state_ff.mem[state_ff.rd_ptr];

   always_comb begin
      logic [7:0] oh;
      logic [3:0] code;
      nxt_state = state_ff;
      oh = decode_grp(apb_in.pwdata[3:0]);
      code = apb_in.pwdata[3:0] - 4'h1;
      nxt_state.tstamp = state_ff.tstamp + 32'h0000_0001;
      nxt_state.rreq = 8'h00;
      nxt_state.lreq = 8'h00;
      nxt_state.fvalid = 1'b0;

      // Group selection
      if (state_ff.force_en) begin
         if (state_ff.fvalid) begin
            if (state_ff.used[state_ff.fgrp]) begin
               nxt_state.active = state_ff.fgrp;
               nxt_state.fail_force = 1'b0;
            end else begin
               nxt_state.fail_force = 1'b1;
            end
         end
      end else begin
         nxt_state.fail_force = state_ff.fvalid;
         if (win_valid && state_ff.used[win]) begin
            nxt_state.active = win;
         end
      end
      nxt_state.fail_notcfg = !state_ff.force_en && win_valid && !state_ff.used[win];
      nxt_state.fail_prio = !state_ff.force_en && blocked;

      // Event capture; pending bits are kept while the buffer is full
      nxt_state.prev = sig;
      nxt_state.pend_on = state_ff.pend_on | new_on;
      nxt_state.pend_off = state_ff.pend_off | new_off;
      if (push) begin
         nxt_state.mem[state_ff.wr_ptr] = '{ts: state_ff.tstamp, id: pick_id, on: use_on};
         nxt_state.wr_ptr = state_ff.wr_ptr + AW'(1);
         if (use_on) begin
            nxt_state.pend_on = (state_ff.pend_on & ~(30'h0000_0001 << pick_id)) | new_on;
         end else begin
            nxt_state.pend_off = (state_ff.pend_off & ~(30'h0000_0001 << pick_id)) | new_off;
         end
      end
      if (pop) begin
         nxt_state.rd_ptr = state_ff.rd_ptr + AW'(1);
      end
      nxt_state.count = state_ff.count + (AW + 1)'(push) - (AW + 1)'(pop);

      // Register writes at the access edge
      if (wr_acc) begin
         unique case (apb_in.paddr)
            OFS_CTRL: nxt_state.force_en = apb_in.pwdata[CTRL_FORCE_BIT];
            OFS_USED: nxt_state.used = apb_in.pwdata[7:0] | USED_RST;
            OFS_REMOTE: nxt_state.rreq = oh;
            OFS_LOCAL: nxt_state.lreq = oh;
            OFS_FORCE: begin
               nxt_state.fvalid = |oh;
               nxt_state.fgrp = code[2:0];
            end
            OFS_ON_EN: nxt_state.on_en = apb_in.pwdata[29:0];
            OFS_OFF_EN: nxt_state.off_en = apb_in.pwdata[29:0];
            OFS_INT_MASK: nxt_state.int_mask = apb_in.pwdata[2:0];
            default: ;
         endcase
      end

      // Sticky status; a set in the clearing cycle wins
      nxt_state.int_status = state_ff.int_status;
      if (wr_acc && apb_in.paddr == OFS_INT_STATUS) begin
         nxt_state.int_status = state_ff.int_status & ~apb_in.pwdata[2:0];
      end
      if (push) begin
         nxt_state.int_status[INT_EVT_BIT] = 1'b1;
      end
      if ((|state_ff.pend_on || |state_ff.pend_off) && state_ff.count == DEPTH_CNT) begin
         nxt_state.int_status[INT_STALL_BIT] = 1'b1;
      end
      if (|new_on[SIG_FAIL_PRIO:SIG_FAIL_NOTCFG]) begin
         nxt_state.int_status[INT_FAIL_BIT] = 1'b1;
      end

      // Read data prepared in setup so it comes from a flop at access
      if (rd_setup) begin
         nxt_state.prdata = 32'h0000_0000;
         nxt_state.pslverr = 1'b0;
         unique case (apb_in.paddr)
            OFS_CTRL: nxt_state.prdata[CTRL_FORCE_BIT] = state_ff.force_en;
            OFS_USED: nxt_state.prdata[7:0] = state_ff.used;
            OFS_REMOTE, OFS_LOCAL, OFS_FORCE, OFS_EVT_POP: ;
            OFS_ACTIVE: begin
               nxt_state.prdata[3:0] = {1'b0, state_ff.active} + 4'h1;
               nxt_state.prdata[ACT_FAIL_NOTCFG_BIT] = state_ff.fail_notcfg;
               nxt_state.prdata[ACT_FAIL_FORCE_BIT] = state_ff.fail_force;
               nxt_state.prdata[ACT_FAIL_PRIO_BIT] = state_ff.fail_prio;
            end
            OFS_ON_EN: nxt_state.prdata[29:0] = state_ff.on_en;
            OFS_OFF_EN: nxt_state.prdata[29:0] = state_ff.off_en;
            OFS_EVT_INFO: begin
               nxt_state.prdata[4:0] = head.id;
               nxt_state.prdata[INFO_ON_BIT] = head.on;
               nxt_state.prdata[INFO_COUNT_LSB +: AW + 1] = state_ff.count;
               nxt_state.prdata[INFO_VALID_BIT] = state_ff.count != '0;
            end
            OFS_EVT_TS: nxt_state.prdata = head.ts;
            OFS_INT_STATUS: nxt_state.prdata[2:0] = state_ff.int_status;
            OFS_INT_MASK: nxt_state.prdata[2:0] = state_ff.int_mask;
            default: nxt_state.pslverr = 1'b1;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_ff <= '0;
         state_ff.active <= ACTIVE_RST;
         state_ff.used <= USED_RST;
         state_ff.on_en <= EN_RST;
         state_ff.off_en <= EN_RST;
         state_ff.prev <= SIG_RST;
         state_ff.int_mask <= INT_MASK_RST;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Zero wait state: the answer is ready in the first access cycle
   assign apb_out.pready = apb_in.psel && apb_in.penable;
   assign apb_out.prdata = state_ff.prdata;
   assign apb_out.pslverr = state_ff.pslverr;
   assign active_group = state_ff.active;
   assign irq = |(state_ff.int_status & state_ff.int_mask);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   property p_first_wins;
      !state_ff.force_en && comb_req[0] |=> state_ff.active == 3'h0;
   endproperty
   a_first_wins: assert property (p_first_wins) else $error("group one request lost");

   property p_five_blocks;
      !state_ff.force_en && comb_req[4] && comb_req[3:0] == 4'h0 && state_ff.used[4]
         |=> state_ff.active == 3'h4;
   endproperty
   a_five_blocks: assert property (p_five_blocks) else $error("group five not selected");

   property p_six_blocks;
      !state_ff.force_en && comb_req[5] && comb_req[4:0] == 5'h00
         |=> state_ff.active != 3'h6 && state_ff.active != 3'h7 || $stable(state_ff.active);
   endproperty
   a_six_blocks: assert property (p_six_blocks) else $error("group six did not block");

   property p_six_rank;
      !state_ff.force_en && comb_req[5] && comb_req[4:0] != 5'h00 && state_ff.used[win]
         |=> state_ff.active != 3'h5;
   endproperty
   a_six_rank: assert property (p_six_rank) else $error("group six outranked higher");

   property p_seven_blocks;
      !state_ff.force_en && comb_req[7:6] == 2'h3 && comb_req[5:0] == 6'h00 && state_ff.used[6]
         |=> state_ff.active == 3'h6;
   endproperty
   a_seven_blocks: assert property (p_seven_blocks) else $error("group seven not over eight");

   property p_eight_no_block;
      !state_ff.force_en && comb_req[7] && comb_req[1] && comb_req[0] == 1'b0 && state_ff.used[1]
         |=> state_ff.active == 3'h1;
   endproperty
   a_eight_no_block: assert property (p_eight_no_block) else $error("group eight blocked");

   property p_hold;
      !state_ff.fvalid && (state_ff.force_en || !win_valid) |=> $stable(state_ff.active);
   endproperty
   a_hold: assert property (p_hold) else $error("active group changed by itself");

   property p_notcfg;
      !state_ff.force_en && !state_ff.fvalid && win_valid && !state_ff.used[win]
         |=> state_ff.fail_notcfg && $stable(state_ff.active);
   endproperty
   a_notcfg: assert property (p_notcfg) else $error("unconfigured request mishandled");

   property p_prio_fail;
      !state_ff.force_en && blocked |=> state_ff.fail_prio;
   endproperty
   a_prio_fail: assert property (p_prio_fail) else $error("blocked request not flagged");

   property p_force_fail;
      state_ff.fvalid && !state_ff.force_en |=> state_ff.fail_force;
   endproperty
   a_force_fail: assert property (p_force_fail) else $error("forced failure not flagged");

   property p_event_logged;
      push |=> state_ff.count != '0 && state_ff.int_status[INT_EVT_BIT];
   endproperty
   a_event_logged: assert property (p_event_logged) else $error("event not stored");

   property p_change_pending;
      (new_on != 30'h0000_0000) |=> (state_ff.pend_on != 30'h0000_0000) || $past(push);
   endproperty
   a_change_pending: assert property (p_change_pending) else $error("ON change lost");

   property p_force_stuck;
      state_ff.force_en && state_ff.fvalid && !state_ff.used[state_ff.fgrp]
         |=> state_ff.fail_force && $stable(state_ff.active);
   endproperty
   a_force_stuck: assert property (p_force_stuck) else $error("failed force not flagged");

   property p_force_apply;
      state_ff.force_en && state_ff.fvalid && state_ff.used[state_ff.fgrp]
         |=> state_ff.active == $past(state_ff.fgrp) && !state_ff.fail_force;
   endproperty
   a_force_apply: assert property (p_force_apply) else $error("forced group not applied");

   property p_stall;
      (state_ff.pend_on != 30'h0000_0000 || state_ff.pend_off != 30'h0000_0000) && state_ff.count == DEPTH_CNT
         |=> state_ff.int_status[INT_STALL_BIT];
   endproperty
   a_stall: assert property (p_stall) else $error("stalled events not flagged");

   c_force: cover property (state_ff.force_en && state_ff.fvalid ##1 state_ff.active == state_ff.fgrp);
   c_block: cover property (blocked ##1 state_ff.fail_prio);
   c_full: cover property (state_ff.count == DEPTH_CNT);
   c_force_fail: cover property (state_ff.force_en && state_ff.fvalid ##1 state_ff.fail_force);
   c_stall: cover property (state_ff.int_status[INT_STALL_BIT]);
endmodule
`default_nettype wire

// ==== sim/req_source.sv ====
`default_nettype none
module req_source (
   input wire logic clk, // Bench clock
   input wire logic sys_rst, // Synchronous reset
   input wire logic [7:0] lvl, // Static request levels
   input wire logic [7:0] pls, // One-cycle pulse strobes
   output logic [7:0] req_out // Request lines to the block
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] pulse_ff;
   // Pulses are re-timed by one clock; each lasts as long as pls is held
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pulse_ff <= 8'h00;
      end else begin
         pulse_ff <= pls;
      end
   end
   assign req_out = lvl | pulse_ff;
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
`default_nettype none
module tb_top
   import group_sel_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk;
   logic sys_rst;
   apb_req_type apb_in;
   apb_rsp_type apb_out;
   logic [7:0] req_in;
   logic [7:0] lvl;
   logic [7:0] pls;
   logic [2:0] active_group;
   logic irq;
   logic [31:0] rd;
   logic err;
   int fails;
   int tests_run;
   int cycles;

   group_selection_function dut_u (
      .clk(clk), .sys_rst(sys_rst), .apb_in(apb_in), .apb_out(apb_out),
      .req_in(req_in), .active_group(active_group), .irq(irq));
   req_source src_u (.clk(clk), .sys_rst(sys_rst), .lvl(lvl), .pls(pls), .req_out(req_in));

   always #5 clk = ~clk;

   task automatic print_verdict();
      $display("fails=%0d tests_run=%0d", fails, tests_run);
      if (fails == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Generous ceiling; the full sequence needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         print_verdict();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      apb_in <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk);
      apb_in.penable <= 1'b1;
      do @(posedge clk); while (apb_out.pready !== 1'b1);
      rd = apb_out.prdata;
      err = apb_out.pslverr;
      apb_in.psel <= 1'b0;
      apb_in.penable <= 1'b0;
   endtask

   task automatic pulse(input int i);
      @(posedge clk);
      pls <= 8'h01 << i;
      @(posedge clk);
      pls <= 8'h00;
   endtask

   task automatic t_reset();
      chk(active_group, 32'h0000_0000);
      chk(irq, 32'h0000_0000);
      apb(1'b0, OFS_USED, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      apb(1'b0, OFS_ON_EN, 32'h0000_0000);
      chk(rd, 32'h3FFF_FFFF);
      apb(1'b0, 8'hFC, 32'h0000_0000);
      chk({rd[30:0], err}, 32'h0000_0001);
   endtask

   // Unused group held: no change, failure event raises irq
   task automatic t_fail();
      apb(1'b1, OFS_INT_MASK, 32'h0000_0004);
      lvl <= 8'h10;
      repeat (6) @(posedge clk);
      chk(irq, 32'h0000_0001);
      chk(active_group, 32'h0000_0000);
      apb(1'b0, OFS_ACTIVE, 32'h0000_0000);
      chk(rd & 32'h0000_070F, 32'h0000_0101);
      apb(1'b0, OFS_EVT_INFO, 32'h0000_0000);
      chk(rd & 32'h8000_01FF, 32'h8000_0104);
      apb(1'b0, OFS_EVT_TS, 32'h0000_0000);
      chk(rd != 32'h0000_0000, 32'h0000_0001);
      apb(1'b1, OFS_EVT_POP, 32'h0000_0000);
      apb(1'b0, OFS_EVT_INFO, 32'h0000_0000);
      chk(rd & 32'h8000_01FF, 32'h8000_011B);
      apb(1'b1, OFS_EVT_POP, 32'h0000_0000);
      apb(1'b1, OFS_INT_STATUS, 32'h0000_0004);
      repeat (2) @(posedge clk);
      chk(irq, 32'h0000_0000);
      apb(1'b1, OFS_OFF_EN, 32'h0000_0000);
      lvl <= 8'h00;
      repeat (6) @(posedge clk);
      apb(1'b0, OFS_EVT_INFO, 32'h0000_0000);
      chk(rd[31], 32'h0000_0000);
   endtask

   // Each level held together with every lower-priority level
   task automatic t_priority();
      apb(1'b1, OFS_USED, 32'h0000_00FF);
      for (int i = 0; i < 8; i++) begin
         lvl <= 8'hFF << i;
         repeat (4) @(posedge clk);
         chk(active_group, i);
         apb(1'b0, OFS_ACTIVE, 32'h0000_0000);
         chk(rd & 32'h0000_070F, ((i < 7) << 10) | (i + 1));
      end
      // No pops since the buffer emptied: head is request one ON, buffer full
      apb(1'b0, OFS_EVT_INFO, 32'h0000_0000);
      chk(rd & 32'h800F_01FF, 32'h8008_0100);
   endtask

   task automatic t_hold();
      lvl <= 8'h00;
      repeat (4) @(posedge clk);
      chk(active_group, 32'h0000_0007);
      pulse(0);
      repeat (4) @(posedge clk);
      chk(active_group, 32'h0000_0000);
   endtask

   task automatic t_force();
      apb(1'b1, OFS_CTRL, 32'h0000_0001);
      apb(1'b1, OFS_FORCE, 32'h0000_0003);
      repeat (3) @(posedge clk);
      chk(active_group, 32'h0000_0002);
      pulse(0);
      repeat (4) @(posedge clk);
      chk(active_group, 32'h0000_0002);
      // Group eight removed, then forced: group stays, failure sticks
      apb(1'b1, OFS_USED, 32'h0000_007F);
      apb(1'b1, OFS_FORCE, 32'h0000_0008);
      repeat (2) @(posedge clk);
      apb(1'b0, OFS_ACTIVE, 32'h0000_0000);
      chk(rd & 32'h0000_070F, 32'h0000_0203);
      apb(1'b1, OFS_CTRL, 32'h0000_0000);
      apb(1'b1, OFS_REMOTE, 32'h0000_0004);
      repeat (3) @(posedge clk);
      chk(active_group, 32'h0000_0003);
      apb(1'b1, OFS_LOCAL, 32'h0000_0002);
      repeat (3) @(posedge clk);
      chk(active_group, 32'h0000_0001);
      apb(1'b0, OFS_INT_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0007);
      chk(irq, 32'h0000_0001);
   endtask

   initial begin
      clk = 1'b0;
      sys_rst = 1'b1;
      apb_in = '0;
      lvl = 8'h00;
      pls = 8'h00;
      fails = 0;
      tests_run = 0;
      cycles = 0;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_fail();
      t_priority();
      t_hold();
      t_force();
      print_verdict();
   end
endmodule
`default_nettype wire
